// ===== fan_regs.svh
// register offsets, field positions, reset values and timing counts of the fan control limit registers
`ifndef FAN_REGS_SVH
`define FAN_REGS_SVH

// register offsets
`define ACOUSTIC_ADDR        8'h63
`define MIN_DUTY1_ADDR       8'h64
`define MIN_DUTY2_ADDR       8'h65
`define MIN_DUTY3_ADDR       8'h66
`define START_R1_ADDR        8'h67
`define START_LOC_ADDR       8'h68
`define START_R2_ADDR        8'h69
`define LIMIT_R1_ADDR        8'h6A
`define LIMIT_LOC_ADDR       8'h6B
`define LIMIT_R2_ADDR        8'h6C
`define HYST_A_ADDR          8'h6D
`define HYST_B_ADDR          8'h6E
`define TEST_EN_ADDR         8'h6F

// reset values
`define ACOUSTIC_RESET       8'h00
`define MIN_DUTY_RESET       8'h80
`define START_TEMP_RESET     8'h5A
`define LIMIT_RESET          8'h64
`define HYST_A_RESET         8'h44
`define HYST_B_RESET         8'h40
`define TEST_EN_RESET        1'h0

// field positions
`define RAMP_EN_BIT          7
`define RAMP_RATE_HI         6
`define RAMP_RATE_LO         4
`define TEST_EN_BIT          0

// special values
`define LIMIT_DISABLE        8'h80
`define DUTY_FULL            8'hFF
`define DUTY_OFF             8'h00
`define READ_UNMAPPED        8'h00

// ramp increments per time slot, indexed by the 3-bit rate code
`define RAMP_STEP_0          8'h01
`define RAMP_STEP_1          8'h02
`define RAMP_STEP_2          8'h03
`define RAMP_STEP_3          8'h05
`define RAMP_STEP_4          8'h08
`define RAMP_STEP_5          8'h0C
`define RAMP_STEP_6          8'h18
`define RAMP_STEP_7          8'h30

// ramp time slot
`define CLK_PERIOD_NS        10
`define RAMP_SLOT_MS         200
`define RAMP_SLOT_CYCLES     ((`RAMP_SLOT_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// ===== fan_pkg.sv
// types shared by the fan control limit register block
package fan_pkg;

    typedef logic [7:0] byte_t;

    // one register access from the management bus engine
    typedef struct packed {
        logic  wr;
        logic  rd;
        byte_t addr;
        byte_t wdata;
    } reg_req_s;

    // per channel inputs: index 0 remote 1, 1 local, 2 remote 2
    typedef struct packed {
        logic [2:0][9:0] reading;   // unsigned, 0.25 degree per lsb
        logic [2:0][7:0] span;      // duty added per degree above start
    } chan_in_s;

    // register and control state of the core
    typedef struct packed {
        byte_t            acoustic;
        logic [2:0][7:0]  min_duty;
        logic [2:0][7:0]  start;
        logic [2:0][7:0]  limit;
        byte_t            hyst_a;
        byte_t            hyst_b;
        logic             test_en;
        byte_t            rdata;
        logic [2:0]       running;
        logic [2:0]       tripped;
        logic [2:0][7:0]  duty;
        logic             ot_oe;
    } core_state_s;

    // ramp unit state
    typedef struct packed {
        logic [31:0] slot_cnt;
        byte_t       duty;
    } ramp_state_s;

endpackage : fan_pkg

// ===== fan_ramp.sv
// gradual duty ramp for the second fan output
`include "fan_regs.svh"

module fan_ramp #(
    parameter int unsigned SLOT_CYCLES = `RAMP_SLOT_CYCLES
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rstn,
    // control
    input  wire logic         enable,
    input  wire logic [2:0]   rate,
    input  wire fan_pkg::byte_t target,
    // ramped duty
    output      fan_pkg::byte_t duty
);
    import fan_pkg::*;

    ramp_state_s s;
    ramp_state_s next_s;
    byte_t       step;
    logic        slot_end;

    // increment per slot from the rate code
    always_comb begin
        case (rate)
            3'h0:    step = `RAMP_STEP_0;
            3'h1:    step = `RAMP_STEP_1;
            3'h2:    step = `RAMP_STEP_2;
            3'h3:    step = `RAMP_STEP_3;
            3'h4:    step = `RAMP_STEP_4;
            3'h5:    step = `RAMP_STEP_5;
            3'h6:    step = `RAMP_STEP_6;
            default: step = `RAMP_STEP_7;
        endcase
    end

    assign slot_end = (s.slot_cnt == 32'(SLOT_CYCLES - 1));

    // step toward the target once per slot, never past it
    always_comb begin
        next_s          = s;
        next_s.slot_cnt = slot_end ? 32'h0 : s.slot_cnt + 32'h1;
        if (!enable) begin
            next_s.duty = target;
        end else if (slot_end) begin
            if (target > s.duty) begin
                next_s.duty = ((target - s.duty) > step) ? byte_t'(s.duty + step) : target;
            end else if (target < s.duty) begin
                next_s.duty = ((s.duty - target) > step) ? byte_t'(s.duty - step) : target;
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s <= '{slot_cnt: 32'h0, duty: `DUTY_OFF};
        end else begin
            s <= next_s;
        end
    end

    assign duty = s.duty;

endmodule : fan_ramp

// ===== fan_limits.sv
// fan control limit registers with automatic duty, fail-safe and overtemperature pin
//
// Overview of operation
// - the second fan output ramps gradually only while bit 7 of the acoustic register is 1.
// - with ramping on, the second fan output steps toward its new duty at the rate chosen by bits 6 to 4.
// - while the lock input is 1, writes to the acoustic, start, critical and hysteresis registers are dropped.
// - the three minimum duty registers drop writes while automatic fan control is active.
// - a minimum duty byte maps linearly onto duty, 0x00 off and 0xFF full speed.
// - above its start temperature a fan runs at minimum duty plus span per degree of excess.
// - any channel over its critical limit forces every fan output to full duty.
// - a critical limit of 0x80 disables the fail-safe for that channel.
// - a tripped channel holds full duty until it falls below its limit minus its hysteresis.
// - the overtemperature pin is pulled low when enabled and a reading exceeds a limit by 0.25 degree.
// - below start temperature a running fan keeps minimum duty until start minus hysteresis is reached.
// - bit 0 of the test enable register selects the parity tree test mode while it is 1.
`include "fan_regs.svh"

module fan_limits #(
    parameter int unsigned RAMP_SLOT_CYCLES = `RAMP_SLOT_CYCLES
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // register access
    input  wire fan_pkg::reg_req_s reg_req,
    output      fan_pkg::byte_t    rdata,
    // configuration bits held elsewhere
    input  wire logic              cfg_lock,
    input  wire logic              auto_mode,
    input  wire logic              overtemp_out_en,
    // measured temperatures and spans
    input  wire fan_pkg::chan_in_s chan_in,
    // fan duties
    output      fan_pkg::byte_t    fan_out_one,
    output      fan_pkg::byte_t    fan_out_two,
    output      fan_pkg::byte_t    fan_out_three,
    // overtemperature open-drain pin
    output      logic              overtemp_pin_o,
    output      logic              overtemp_pin_oe,
    // status and test mode
    output      logic              failsafe_active,
    output      logic              parity_tree_test_en
);
    import fan_pkg::*;

    localparam core_state_s RESET_STATE = '{
        acoustic: `ACOUSTIC_RESET,
        min_duty: {3{`MIN_DUTY_RESET}},
        start:    {3{`START_TEMP_RESET}},
        limit:    {3{`LIMIT_RESET}},
        hyst_a:   `HYST_A_RESET,
        hyst_b:   `HYST_B_RESET,
        test_en:  `TEST_EN_RESET,
        rdata:    `READ_UNMAPPED,
        running:  3'h0,
        tripped:  3'h0,
        duty:     {3{`DUTY_OFF}},
        ot_oe:    1'h0
    };

    core_state_s     s;
    core_state_s     next_s;
    logic [2:0][3:0] hyst;
    logic [2:0]      above_start;
    logic [2:0]      run_release;
    logic [2:0]      over_limit;
    logic [2:0]      trip_release;
    logic [2:0]      ot_hit;
    logic [2:0][7:0] target;
    byte_t           ramp_duty;
    logic            any_trip;
    logic            wr_locked;
    logic            wr_duty;

    ////////////////////////////////////////////////////////////////////////////////////////////////////
    // per channel comparisons

    // nibble placement of the hysteresis fields
    assign hyst[0] = s.hyst_a[7:4];
    assign hyst[1] = s.hyst_a[3:0];
    assign hyst[2] = s.hyst_b[7:4];

    for (genvar ch = 0; ch < 3; ch++) begin : g_chan
        logic [7:0]  deg;
        logic [7:0]  excess;
        logic [15:0] slope;
        logic [16:0] sum;
        logic [8:0]  deg_plus_hyst;

        // whole degrees of the reading, compared unsigned
        assign deg           = chan_in.reading[ch][9:2];
        assign deg_plus_hyst = {1'b0, deg} + {5'h00, hyst[ch]};
        assign above_start[ch] = deg > s.start[ch];
        assign run_release[ch] = deg_plus_hyst <= {1'b0, s.start[ch]};
        assign over_limit[ch]  = (s.limit[ch] != `LIMIT_DISABLE) && (deg > s.limit[ch]);
        assign trip_release[ch] = deg_plus_hyst < {1'b0, s.limit[ch]};
        // quarter degree resolution for the pin
        assign ot_hit[ch] = chan_in.reading[ch] > {s.limit[ch], 2'b00};

        // linear duty above start, saturating at full speed
        assign excess = above_start[ch] ? byte_t'(deg - s.start[ch]) : `DUTY_OFF;
        assign slope  = excess * chan_in.span[ch];
        assign sum    = {1'b0, slope} + {9'h000, s.min_duty[ch]};
        // one continuous driver per element keeps the shared target vector single-driven
        assign target[ch] = !s.running[ch] ? `DUTY_OFF
                          : above_start[ch] ? ((sum > 17'(`DUTY_FULL)) ? `DUTY_FULL : sum[7:0])
                          : s.min_duty[ch];
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////////
    // gradual ramp on the second fan

    fan_ramp #(
        .SLOT_CYCLES (RAMP_SLOT_CYCLES)
    ) u_ramp (
        .clk    (clk),
        .rstn   (rstn),
        .enable (s.acoustic[`RAMP_EN_BIT]),
        .rate   (s.acoustic[`RAMP_RATE_HI:`RAMP_RATE_LO]),
        .target (target[1]),
        .duty   (ramp_duty)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////////////
    // register file and control state

    assign wr_locked = reg_req.wr && !cfg_lock;
    assign wr_duty   = reg_req.wr && !auto_mode;

    always_comb begin
        next_s = s;

        // register writes; the lock covers the acoustic, start, critical and hysteresis registers
        if (wr_duty) begin
            case (reg_req.addr)
                `MIN_DUTY1_ADDR: next_s.min_duty[0] = reg_req.wdata;
                `MIN_DUTY2_ADDR: next_s.min_duty[1] = reg_req.wdata;
                `MIN_DUTY3_ADDR: next_s.min_duty[2] = reg_req.wdata;
                default: ;
            endcase
        end
        if (wr_locked) begin
            case (reg_req.addr)
                `ACOUSTIC_ADDR:  next_s.acoustic = reg_req.wdata;
                `START_R1_ADDR:  next_s.start[0] = reg_req.wdata;
                `START_LOC_ADDR: next_s.start[1] = reg_req.wdata;
                `START_R2_ADDR:  next_s.start[2] = reg_req.wdata;
                `LIMIT_R1_ADDR:  next_s.limit[0] = reg_req.wdata;
                `LIMIT_LOC_ADDR: next_s.limit[1] = reg_req.wdata;
                `LIMIT_R2_ADDR:  next_s.limit[2] = reg_req.wdata;
                `HYST_A_ADDR:    next_s.hyst_a   = reg_req.wdata;
                `HYST_B_ADDR:    next_s.hyst_b   = reg_req.wdata;
                default: ;
            endcase
        end
        // upper bits are not stored, so a stray write there is harmless
        if (reg_req.wr && (reg_req.addr == `TEST_EN_ADDR)) begin
            next_s.test_en = reg_req.wdata[`TEST_EN_BIT];
        end

        // read data, registered; unmapped offsets read zero
        if (reg_req.rd) begin
            case (reg_req.addr)
                `ACOUSTIC_ADDR:  next_s.rdata = s.acoustic;
                `MIN_DUTY1_ADDR: next_s.rdata = s.min_duty[0];
                `MIN_DUTY2_ADDR: next_s.rdata = s.min_duty[1];
                `MIN_DUTY3_ADDR: next_s.rdata = s.min_duty[2];
                `START_R1_ADDR:  next_s.rdata = s.start[0];
                `START_LOC_ADDR: next_s.rdata = s.start[1];
                `START_R2_ADDR:  next_s.rdata = s.start[2];
                `LIMIT_R1_ADDR:  next_s.rdata = s.limit[0];
                `LIMIT_LOC_ADDR: next_s.rdata = s.limit[1];
                `LIMIT_R2_ADDR:  next_s.rdata = s.limit[2];
                `HYST_A_ADDR:    next_s.rdata = s.hyst_a;
                `HYST_B_ADDR:    next_s.rdata = s.hyst_b;
                `TEST_EN_ADDR:   next_s.rdata = {7'h00, s.test_en};
                default:         next_s.rdata = `READ_UNMAPPED;
            endcase
        end

        // channel running with hysteresis below start
        for (int ch = 0; ch < 3; ch++) begin
            if (above_start[ch]) begin
                next_s.running[ch] = 1'b1;
            end else if (run_release[ch]) begin
                next_s.running[ch] = 1'b0;
            end
            // trip latches until the reading falls below limit minus hysteresis or the limit is set to 0x80
            if (over_limit[ch]) begin
                next_s.tripped[ch] = 1'b1;
            end else if (trip_release[ch] || (s.limit[ch] == `LIMIT_DISABLE)) begin
                next_s.tripped[ch] = 1'b0;
            end
        end

        // fail-safe overrides every output, the ramp included
        next_s.duty[0] = any_trip ? `DUTY_FULL : target[0];
        next_s.duty[1] = any_trip ? `DUTY_FULL : ramp_duty;
        next_s.duty[2] = any_trip ? `DUTY_FULL : target[2];
        next_s.ot_oe   = overtemp_out_en && (|ot_hit);
    end

    assign any_trip = |s.tripped;

    // state register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s <= RESET_STATE;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////////
    // outputs, all from the state register except the tied-low pin data

    assign rdata               = s.rdata;
    assign fan_out_one         = s.duty[0];
    assign fan_out_two         = s.duty[1];
    assign fan_out_three       = s.duty[2];
    assign overtemp_pin_o      = 1'b0;       // open drain: only ever pulls low
    assign overtemp_pin_oe     = s.ot_oe;
    assign failsafe_active     = any_trip;
    assign parity_tree_test_en = s.test_en;

endmodule : fan_limits

// ===== fan_limits_chk.sv
// assertion checker for the fan control limit registers
`include "fan_regs.svh"
module fan_limits_chk #(
    parameter int unsigned RAMP_SLOT_CYCLES = 4
) (
    // clock and reset
    input wire logic              clk,
    input wire logic              rstn,
    // register access
    input wire fan_pkg::reg_req_s reg_req,
    input wire fan_pkg::byte_t    rdata,
    // configuration and temperatures
    input wire logic              cfg_lock,
    input wire logic              auto_mode,
    input wire logic              overtemp_out_en,
    input wire fan_pkg::chan_in_s chan_in,
    // outputs
    input wire fan_pkg::byte_t    fan_out_one,
    input wire fan_pkg::byte_t    fan_out_two,
    input wire fan_pkg::byte_t    fan_out_three,
    input wire logic              overtemp_pin_o,
    input wire logic              overtemp_pin_oe,
    input wire logic              failsafe_active,
    input wire logic              parity_tree_test_en
);
    import fan_pkg::*;
    logic test_wr;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////////
    // write to the test register, kept as a signal so $past sees one name
    assign test_wr = reg_req.wr && reg_req.addr == `TEST_EN_ADDR;
    a_failsafe_full_duty: assert property (
        failsafe_active |=> fan_out_one == `DUTY_FULL && fan_out_two == `DUTY_FULL && fan_out_three == `DUTY_FULL)
        else $error("fan output below full duty during fail-safe");
    // unchanged readings, limits and hysteresis can never release a trip
    a_trip_hold: assert property (
        failsafe_active && $stable(chan_in.reading) && !$past(reg_req.wr) |=> failsafe_active)
        else $error("fail-safe released with steady readings");
    a_pin_data_low: assert property (overtemp_pin_o == 1'b0)
        else $error("overtemp pin data not low");
    a_pin_needs_en: assert property (!overtemp_out_en |=> !overtemp_pin_oe)
        else $error("overtemp pin driven while not an output");
    a_pin_with_trip: assert property (
        $rose(failsafe_active) && $past(overtemp_out_en) |-> overtemp_pin_oe)
        else $error("overtemp pin idle at trip");
    a_test_write: assert property (test_wr |=> parity_tree_test_en == $past(reg_req.wdata[0]))
        else $error("test enable does not follow write");
    a_test_cause: assert property ($changed(parity_tree_test_en) |-> $past(test_wr))
        else $error("test enable moved without a write");
    a_test_upper_zero: assert property (
        reg_req.rd && reg_req.addr == `TEST_EN_ADDR |=> rdata[7:1] == 7'h00)
        else $error("unused test bits read nonzero");
endmodule : fan_limits_chk

bind fan_limits fan_limits_chk #(.RAMP_SLOT_CYCLES(RAMP_SLOT_CYCLES)) u_chk (.clk(clk), .rstn(rstn),
    .reg_req(reg_req), .rdata(rdata), .cfg_lock(cfg_lock), .auto_mode(auto_mode),
    .overtemp_out_en(overtemp_out_en), .chan_in(chan_in), .fan_out_one(fan_out_one),
    .fan_out_two(fan_out_two), .fan_out_three(fan_out_three), .overtemp_pin_o(overtemp_pin_o),
    .overtemp_pin_oe(overtemp_pin_oe), .failsafe_active(failsafe_active),
    .parity_tree_test_en(parity_tree_test_en));

// ===== fan_host.sv
// management bus host model issuing single byte register accesses
`include "fan_regs.svh"
module fan_host (
    // clock
    input  wire logic             clk,
    // register access
    output      fan_pkg::reg_req_s req,
    input  wire fan_pkg::byte_t   rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import fan_pkg::*;
    initial req = '0;
    ////////////////////////////////////////////////////////////////////////////////
    // requests launch at a falling edge and stand for one full cycle
    task automatic wr(input byte_t a, input byte_t d);
        byte_t v;
        v = d;
        if (a == `TEST_EN_ADDR) v = v & 8'h01;
        if (a == `HYST_A_ADDR || a == `HYST_B_ADDR) begin
            // small hysteresis makes the fan cycle, so never program below 4
            if (v[7:4] < 4'h4) v[7:4] = 4'h4;
            if (a == `HYST_A_ADDR && v[3:0] < 4'h4) v[3:0] = 4'h4;
        end
        @(negedge clk);
        req <= '{1'b1, 1'b0, a, v};
        @(negedge clk);
        req <= '0;
    endtask : wr
    // read data lands on the edge that takes the request
    task automatic rd(input byte_t a, output byte_t d);
        @(negedge clk);
        req <= '{1'b0, 1'b1, a, 8'h00};
        @(negedge clk);
        req <= '0;
        d = rdata;
    endtask : rd
endmodule : fan_host

// ===== fan_limits_tb_top.sv
// self-checking bench for the fan control limit registers
`include "fan_regs.svh"
module fan_limits_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import fan_pkg::*;
    typedef struct { byte_t a; byte_t d; byte_t e; } row_s;
    localparam int unsigned SLOT = 4;
    logic     clk = 1'b0;
    logic     rstn = 1'b0;
    logic     cfg_lock = 1'b0;
    logic     auto_mode = 1'b0;
    logic     overtemp_out_en = 1'b0;
    chan_in_s chan_in = '0;
    reg_req_s reg_req;
    byte_t    rdata, fan1, fan2, fan3, v;
    logic     pin_o, pin_oe, failsafe, test_en;
    int       err_total = 0;
    int       tests_run = 0;
    int       cycles = 0;
    int       n;
    byte_t    defs[13] = '{8'h00, 8'h80, 8'h80, 8'h80, 8'h5A, 8'h5A, 8'h5A, 8'h64, 8'h64, 8'h64, 8'h44, 8'h40, 8'h00};
    byte_t    locked[4] = '{8'h63, 8'h67, 8'h6A, 8'h6D};
    byte_t    steps[8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0C, 8'h18, 8'h30};
    // register rows: offset, byte written, byte read back
    row_s rows[14] = '{'{8'h63, 8'h00, 8'h00}, '{8'h64, 8'h40, 8'h40}, '{8'h65, 8'h20, 8'h20},
        '{8'h66, 8'hFF, 8'hFF}, '{8'h67, 8'h1E, 8'h1E}, '{8'h68, 8'h1E, 8'h1E}, '{8'h69, 8'h1E, 8'h1E},
        '{8'h6A, 8'h32, 8'h32}, '{8'h6B, 8'h80, 8'h80}, '{8'h6C, 8'h32, 8'h32}, '{8'h6D, 8'h54, 8'h54},
        '{8'h6E, 8'h64, 8'h64}, '{8'h6F, 8'h01, 8'h01}, '{8'h70, 8'h55, 8'h00}};
    // control rows: whole degrees, channel, expected first fan duty
    row_s ctl[10] = '{'{8'd30, 8'd0, 8'h00}, '{8'd32, 8'd0, 8'h60}, '{8'd30, 8'd0, 8'h40},
        '{8'd26, 8'd0, 8'h40}, '{8'd25, 8'd0, 8'h00}, '{8'd144, 8'd1, 8'h00}, '{8'd0, 8'd1, 8'h00},
        '{8'd51, 8'd2, 8'hFF}, '{8'd44, 8'd2, 8'hFF}, '{8'd43, 8'd2, 8'h00}};

    fan_limits #(.RAMP_SLOT_CYCLES(SLOT)) DUT (.clk(clk), .rstn(rstn), .reg_req(reg_req), .rdata(rdata),
        .cfg_lock(cfg_lock), .auto_mode(auto_mode), .overtemp_out_en(overtemp_out_en), .chan_in(chan_in),
        .fan_out_one(fan1), .fan_out_two(fan2), .fan_out_three(fan3), .overtemp_pin_o(pin_o),
        .overtemp_pin_oe(pin_oe), .failsafe_active(failsafe), .parity_tree_test_en(test_en));
    fan_host host (.clk(clk), .req(reg_req), .rdata(rdata));

    ////////////////////////////////////////////////////////////////////////////////
    // clock and a ceiling well above the few thousand cycles the run needs
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            err_total = err_total + 1;
            conclude();
        end
    end

    task automatic check(input byte_t seen, input byte_t exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic rdchk(input byte_t a, input byte_t e);
        host.rd(a, v);
        check(v, e);
    endtask : rdchk
    task automatic setdeg(input int ch, input byte_t d);
        @(negedge clk);
        chan_in.reading[ch] = {d, 2'b00};
    endtask : setdeg
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence: table rows first, awkward cases after
    initial begin
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        for (int i = 0; i < 13; i++) rdchk(8'h63 + 8'(i), defs[i]);
        check(fan1, `DUTY_OFF);
        for (int i = 0; i < 14; i++) begin
            host.wr(rows[i].a, rows[i].d);
            rdchk(rows[i].a, rows[i].e);
        end
        check({7'h00, test_en}, 8'h01);
        host.wr(`TEST_EN_ADDR, 8'h00);
        check({7'h00, test_en}, 8'h00);
        $display("test registers done");
        cfg_lock = 1'b1;
        for (int i = 0; i < 4; i++) begin
            host.rd(locked[i], v);
            host.wr(locked[i], 8'hAA);
            rdchk(locked[i], v);
        end
        cfg_lock = 1'b0;
        auto_mode = 1'b1;
        host.wr(`MIN_DUTY1_ADDR, 8'h11);
        rdchk(`MIN_DUTY1_ADDR, 8'h40);
        $display("test write protection done");
        chan_in.span[0] = 8'h10;
        overtemp_out_en = 1'b1;
        for (int i = 0; i < 10; i++) begin
            setdeg(ctl[i].d, ctl[i].a);
            repeat (4) @(negedge clk);
            check(fan1, ctl[i].e);
        end
        chan_in.reading[2] = 10'd201;
        repeat (4) @(negedge clk);
        check({failsafe, pin_oe}, 8'h01);
        overtemp_out_en = 1'b0;
        chan_in.reading[2] = 10'd204;
        repeat (4) @(negedge clk);
        check({failsafe, pin_oe}, 8'h02);
        setdeg(2, 8'd0);
        repeat (4) @(negedge clk);
        $display("test automatic control done");
        chan_in.span[1] = 8'h40;
        for (int r = 0; r < 8; r++) begin
            n = (255 + steps[r] - 1) / steps[r];
            host.wr(`ACOUSTIC_ADDR, {1'b1, 3'(r), 4'h0});
            setdeg(1, 8'd0);
            repeat ((n + 2) * SLOT) @(negedge clk);
            check(fan2, `DUTY_OFF);
            setdeg(1, 8'd34);
            repeat ((n - 2) * SLOT) @(negedge clk);
            check({7'h00, fan2 == `DUTY_FULL}, 8'h00);
            repeat (4 * SLOT + 4) @(negedge clk);
            check(fan2, `DUTY_FULL);
        end
        host.wr(`ACOUSTIC_ADDR, 8'h70);
        setdeg(1, 8'd0);
        repeat (4) @(negedge clk);
        check(fan2, `DUTY_OFF);
        $display("test ramp done");
        // mid-run reset must bring the registers back to their defaults
        host.wr(`HYST_A_ADDR, 8'h77);
        @(negedge clk);
        rstn = 1'b0;
        @(negedge clk);
        rstn = 1'b1;
        rdchk(`ACOUSTIC_ADDR, `ACOUSTIC_RESET);
        rdchk(`HYST_A_ADDR, `HYST_A_RESET);
        rdchk(`MIN_DUTY1_ADDR, `MIN_DUTY_RESET);
        $display("test reset done");
        conclude();
    end
endmodule : fan_limits_tb_top
